// ---- design/bsu_consts.vh ----
`ifndef BSU_CONSTS_VH
`define BSU_CONSTS_VH

// Clock rate and supervision time base
`define BSU_CLK_HZ          25000000
`define BSU_TICK_S          1
`define BSU_SEC_CYCLES      (`BSU_CLK_HZ * `BSU_TICK_S)

// Register offsets (word index on the plain port)
`define BSU_REG_CTRL        4'h0
`define BSU_REG_SYNC_DLY    4'h1
`define BSU_REG_UNLD_DLY    4'h2
`define BSU_REG_TRIP        4'h3
`define BSU_REG_STATUS      4'h4
`define BSU_REG_INT_STAT    4'h5
`define BSU_REG_INT_MASK    4'h6
`define BSU_REG_ACK         4'h7
`define BSU_REG_SYNC_TMR    4'h8
`define BSU_REG_UNLD_TMR    4'h9

// Control register fields
`define BSU_CTRL_SYNC_MON   0
`define BSU_CTRL_SYNC_AUTO  1
`define BSU_CTRL_SYNC_LOCK  2
`define BSU_CTRL_UNLD_AUTO  3
`define BSU_CTRL_UNLD_LOCK  4
`define BSU_CTRL_SCLS_LO    8
`define BSU_CTRL_UCLS_LO    12
`define BSU_CTRL_RESET      16'h1101

// Alarm classes A..F and Control
`define BSU_CLASS_B         3'h1
`define BSU_CLASS_MAX       3'h6

// Interrupt and status bit positions
`define BSU_EV_SYNC_TO      0
`define BSU_EV_UNLD_MIS     1
`define BSU_EV_OPEN_CMD     2

// Delay limits in seconds, trip level in tenths of a percent
`define BSU_SYNC_DLY_MIN    10'h003
`define BSU_SYNC_DLY_MAX    10'h3E7
`define BSU_SYNC_DLY_RESET  10'h03C
`define BSU_UNLD_DLY_MIN    10'h001
`define BSU_UNLD_DLY_MAX    10'h3E7
`define BSU_UNLD_DLY_RESET  10'h03C
`define BSU_TRIP_MIN        10'h005
`define BSU_TRIP_MAX        10'h3E7
`define BSU_TRIP_RESET      10'h01E

`endif

// ---- design/bsu_monitor.v ----
`timescale 1ns/1ps
`include "bsu_consts.vh"

// Notes on behaviour
// - Sync supervision only while monitoring enabled.
// - Sync timeout alarm after 3-999 s delay.
// - Timeout posts message and sets command flag.
// - Each alarm has class A-F/Control, default B.
// - Auto clear drops alarm once fault gone.
// - Otherwise alarm latched until acknowledge, or for sync until monitoring disabled.
// - Lockable alarm evaluated only while unlocked.
// - Non-lockable alarm evaluated always.
// - Power below trip level commands breaker open.
// - Unload delay expiry: open, alarm, flag.
module bsu_monitor #(
  parameter SEC_CYCLES = `BSU_SEC_CYCLES,
  parameter PWR_W      = 10
) (
  // Clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // Register port
  input  wire [3:0]       reg_addr,
  input  wire [15:0]      reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output reg  [15:0]      reg_rdata,
  // Discrete inputs from the breaker side
  input  wire             sync_active,
  input  wire             unload_active,
  input  wire             lock_monitoring,
  input  wire             ext_ack,
  // Measured system A power, tenths of a percent of rated_power_a
  input  wire [PWR_W-1:0] power_a,
  // Alarm and command outputs
  output reg              sync_timeout_message,
  output reg              sync_timeout_flag,
  output reg              unload_mismatch_alarm,
  output reg              unload_mismatch_flag,
  output reg              breaker_a_open_cmd,
  output reg  [2:0]       sync_alarm_class,
  output reg  [2:0]       unload_alarm_class,
  output reg              irq
);

  // Input synchroniser stages and filtered levels
  reg  [3:0]  in_s1;
  reg  [3:0]  in_s2;
  reg  [3:0]  in_s3;
  reg  [3:0]  in_f;
  wire [3:0]  in_raw;
  reg         ack_f_d;

  // Registers
  reg  [15:0] ctrl;
  reg  [9:0]  sync_dly;
  reg  [9:0]  unld_dly;
  reg  [9:0]  trip;
  reg  [2:0]  int_stat;
  reg  [2:0]  int_mask;

  // Time base and supervision state
  reg  [31:0] div_cnt;
  reg         sec_tick;
  reg  [9:0]  sync_tmr;
  reg  [9:0]  unld_tmr;
  reg         sync_run;
  reg         unld_run;
  reg         sync_exp;
  reg         unld_exp;
  reg         unld_done;

  wire        f_sync;
  wire        f_unld;
  wire        f_lock;
  wire        ack_rise;
  wire        sw_ack_sync;
  wire        sw_ack_unld;
  wire        ack_sync;
  wire        ack_unld;
  wire        sync_eval;
  wire        unld_eval;
  wire        below_trip;
  wire        sync_to_hit;
  wire        unld_to_hit;
  wire        sync_fault;
  wire        unld_fault;
  wire        open_set;
  wire [2:0]  ev;
  wire        wr_ctrl;
  wire [2:0]  cls_s;
  wire [2:0]  cls_u;
  reg  [9:0]  next_sync_dly;
  reg  [9:0]  next_unld_dly;
  reg  [9:0]  next_trip;
  reg  [15:0] next_rdata;

  assign in_raw = {ext_ack, lock_monitoring, unload_active, sync_active};

  // Three-stage sync, level accepted when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          in_s1[gi] <= 1'b0;
          in_s2[gi] <= 1'b0;
          in_s3[gi] <= 1'b0;
          in_f[gi]  <= 1'b0;
        end else begin
          in_s1[gi] <= in_raw[gi];
          in_s2[gi] <= in_s1[gi];
          in_s3[gi] <= in_s2[gi];
          if (in_s2[gi] == in_s3[gi]) begin
            in_f[gi] <= in_s3[gi];
          end
        end
      end
    end
  endgenerate

  assign f_sync   = in_f[0];
  assign f_unld   = in_f[1];
  assign f_lock   = in_f[2];
  assign ack_rise = in_f[3] & ~ack_f_d;

  // Acknowledge from software writes or a rising edge of ext_ack
  assign sw_ack_sync = reg_wr && (reg_addr == `BSU_REG_ACK) && reg_wdata[`BSU_EV_SYNC_TO];
  assign sw_ack_unld = reg_wr && (reg_addr == `BSU_REG_ACK) && reg_wdata[`BSU_EV_UNLD_MIS];
  assign ack_sync    = ack_rise | sw_ack_sync;
  assign ack_unld    = ack_rise | sw_ack_unld;

  assign sync_eval = ~ctrl[`BSU_CTRL_SYNC_LOCK] | ~f_lock;
  assign unld_eval = ~ctrl[`BSU_CTRL_UNLD_LOCK] | ~f_lock;

  assign below_trip = ({{(16-PWR_W){1'b0}}, power_a} < {6'h00, trip});

  assign sync_to_hit = sync_run && !sync_exp && (sync_tmr >= sync_dly) && ctrl[`BSU_CTRL_SYNC_MON] && sync_eval;
  assign unld_to_hit = unld_run && !unld_exp && !unld_done && !below_trip && (unld_tmr >= unld_dly);

  // Fault present while the expired sequence is still running
  assign sync_fault = sync_exp & f_sync;
  assign unld_fault = unld_exp & f_unld;
  assign open_set   = (unld_run & !unld_done & below_trip) | unld_to_hit;

  assign ev = {open_set & ~breaker_a_open_cmd, unld_to_hit & unld_eval, sync_to_hit};

  // One-second enable divider
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt  <= 32'h00000000;
      sec_tick <= 1'b0;
    end else if (div_cnt >= SEC_CYCLES - 1) begin
      div_cnt  <= 32'h00000000;
      sec_tick <= 1'b1;
    end else begin
      div_cnt  <= div_cnt + 32'h00000001;
      sec_tick <= 1'b0;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_run <= 1'b0;
      sync_tmr <= 10'h000;
      sync_exp <= 1'b0;
    end else if (!f_sync) begin
      sync_run <= 1'b0;
      sync_tmr <= 10'h000;
      sync_exp <= 1'b0;
    end else begin
      sync_run <= 1'b1;
      if (sync_to_hit) begin
        sync_exp <= 1'b1;
      end
      if (sync_run && sec_tick && sync_tmr != 10'h3FF) begin
        sync_tmr <= sync_tmr + 10'h001;
      end
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      unld_run  <= 1'b0;
      unld_tmr  <= 10'h000;
      unld_exp  <= 1'b0;
      unld_done <= 1'b0;
    end else if (!f_unld) begin
      unld_run  <= 1'b0;
      unld_tmr  <= 10'h000;
      unld_exp  <= 1'b0;
      unld_done <= 1'b0;
    end else begin
      unld_run <= 1'b1;
      if (unld_run && !unld_exp && below_trip) begin
        unld_done <= 1'b1;
        unld_tmr  <= 10'h000;
      end else if (unld_to_hit) begin
        unld_exp <= 1'b1;
      end else if (unld_run && !unld_done && !unld_exp && sec_tick && unld_tmr != 10'h3FF) begin
        unld_tmr <= unld_tmr + 10'h001;
      end
    end
  end

  // Alarm latches and command outputs
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_timeout_message  <= 1'b0;
      sync_timeout_flag     <= 1'b0;
      unload_mismatch_alarm <= 1'b0;
      unload_mismatch_flag  <= 1'b0;
      breaker_a_open_cmd    <= 1'b0;
      ack_f_d               <= 1'b0;
    end else begin
      ack_f_d <= in_f[3];
      sync_timeout_message <= sync_to_hit;
      if (sync_to_hit) begin
        sync_timeout_flag <= 1'b1;
      end else if (!ctrl[`BSU_CTRL_SYNC_MON]) begin
        sync_timeout_flag <= 1'b0;
      end else if (!sync_fault && (ctrl[`BSU_CTRL_SYNC_AUTO] || ack_sync)) begin
        sync_timeout_flag <= 1'b0;
      end
      if (unld_to_hit && unld_eval) begin
        unload_mismatch_alarm <= 1'b1;
        unload_mismatch_flag  <= 1'b1;
      end else if (!unld_fault && (ctrl[`BSU_CTRL_UNLD_AUTO] || ack_unld)) begin
        unload_mismatch_alarm <= 1'b0;
        unload_mismatch_flag  <= 1'b0;
      end
      if (open_set) begin
        breaker_a_open_cmd <= 1'b1;
      end else if (!f_unld) begin
        breaker_a_open_cmd <= 1'b0;
      end
    end
  end

  // Clamp written values into their legal ranges
  always @* begin
    next_sync_dly = reg_wdata[9:0];
    if (reg_wdata[9:0] < `BSU_SYNC_DLY_MIN) begin
      next_sync_dly = `BSU_SYNC_DLY_MIN;
    end else if (reg_wdata[9:0] > `BSU_SYNC_DLY_MAX) begin
      next_sync_dly = `BSU_SYNC_DLY_MAX;
    end
    next_unld_dly = reg_wdata[9:0];
    if (reg_wdata[9:0] < `BSU_UNLD_DLY_MIN) begin
      next_unld_dly = `BSU_UNLD_DLY_MIN;
    end else if (reg_wdata[9:0] > `BSU_UNLD_DLY_MAX) begin
      next_unld_dly = `BSU_UNLD_DLY_MAX;
    end
    next_trip = reg_wdata[9:0];
    if (reg_wdata[9:0] < `BSU_TRIP_MIN) begin
      next_trip = `BSU_TRIP_MIN;
    end else if (reg_wdata[9:0] > `BSU_TRIP_MAX) begin
      next_trip = `BSU_TRIP_MAX;
    end
  end

  assign wr_ctrl = reg_wr && (reg_addr == `BSU_REG_CTRL);
  assign cls_s = (reg_wdata[`BSU_CTRL_SCLS_LO+2:`BSU_CTRL_SCLS_LO] > `BSU_CLASS_MAX) ?
                 `BSU_CLASS_MAX : reg_wdata[`BSU_CTRL_SCLS_LO+2:`BSU_CTRL_SCLS_LO];
  assign cls_u = (reg_wdata[`BSU_CTRL_UCLS_LO+2:`BSU_CTRL_UCLS_LO] > `BSU_CLASS_MAX) ?
                 `BSU_CLASS_MAX : reg_wdata[`BSU_CTRL_UCLS_LO+2:`BSU_CTRL_UCLS_LO];

  // Register writes, interrupt status sets win over clears
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl               <= `BSU_CTRL_RESET;
      sync_dly           <= `BSU_SYNC_DLY_RESET;
      unld_dly           <= `BSU_UNLD_DLY_RESET;
      trip               <= `BSU_TRIP_RESET;
      int_stat           <= 3'h0;
      int_mask           <= 3'h0;
      sync_alarm_class   <= `BSU_CLASS_B;
      unload_alarm_class <= `BSU_CLASS_B;
      irq                <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl               <= {1'b0, cls_u, 1'b0, cls_s, 3'h0, reg_wdata[4:0]};
        sync_alarm_class   <= cls_s;
        unload_alarm_class <= cls_u;
      end
      if (reg_wr && reg_addr == `BSU_REG_SYNC_DLY) begin
        sync_dly <= next_sync_dly;
      end
      if (reg_wr && reg_addr == `BSU_REG_UNLD_DLY) begin
        unld_dly <= next_unld_dly;
      end
      if (reg_wr && reg_addr == `BSU_REG_TRIP) begin
        trip <= next_trip;
      end
      if (reg_wr && reg_addr == `BSU_REG_INT_MASK) begin
        int_mask <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == `BSU_REG_INT_STAT) begin
        int_stat <= (int_stat & ~reg_wdata[2:0]) | ev;
      end else begin
        int_stat <= int_stat | ev;
      end
      irq <= |(int_stat & int_mask);
    end
  end

  // Read mux, unmapped addresses read zero
  always @* begin
    next_rdata = 16'h0000;
    case (reg_addr)
      `BSU_REG_CTRL:     next_rdata = ctrl;
      `BSU_REG_SYNC_DLY: next_rdata = {6'h00, sync_dly};
      `BSU_REG_UNLD_DLY: next_rdata = {6'h00, unld_dly};
      `BSU_REG_TRIP:     next_rdata = {6'h00, trip};
      `BSU_REG_STATUS:   next_rdata = {7'h00, f_lock, unld_done, unld_run, sync_run,
                                       2'h0, breaker_a_open_cmd, unload_mismatch_alarm,
                                       sync_timeout_flag};
      `BSU_REG_INT_STAT: next_rdata = {13'h0000, int_stat};
      `BSU_REG_INT_MASK: next_rdata = {13'h0000, int_mask};
      `BSU_REG_SYNC_TMR: next_rdata = {6'h00, sync_tmr};
      `BSU_REG_UNLD_TMR: next_rdata = {6'h00, unld_tmr};
      default:           next_rdata = 16'h0000;
    endcase
  end

  // Read data registered one cycle after the strobe
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// ---- testbench/bsu_breaker_model.sv ----
`timescale 1ns/1ps
module bsu_breaker_model (
  // Clock and reset
  input wire logic   clk,
  input wire logic   sys_rst,
  // Scenario controls
  input wire logic   run_unload,
  input wire logic   shed_load,
  // From the block
  input wire logic   open_cmd,
  // To the block
  output logic       unload_active,
  output logic [9:0] power_a
);
  logic [2:0] open_cnt;
  logic       opened;

  // Breaker travel time, then contacts stay open until the sequence ends
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      open_cnt <= 3'h0;
      opened <= 1'b0;
    end else begin
      open_cnt <= open_cmd ? open_cnt + {2'h0, open_cnt != 3'h5} : 3'h0;
      opened <= run_unload & (opened | open_cnt == 3'h5);
    end
  end

  // Sequence reply and power: full load, ramps down when shed, zero when open
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      unload_active <= 1'b0;
      power_a <= 10'h3E8;
    end else begin
      unload_active <= run_unload & ~opened;
      if (opened)
        power_a <= 10'h000;
      else if (shed_load)
        power_a <= (power_a > 10'h064) ? power_a - 10'h064 : 10'h000;
      else
        power_a <= 10'h3E8;
    end
  end
endmodule

// ---- testbench/bsu_chk_monitor.sv ----
`timescale 1ns/1ps
module bsu_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Sequence inputs
  input wire logic       sync_active,
  input wire logic       unload_active,
  // Alarm and command outputs
  input wire logic       sync_timeout_message,
  input wire logic       sync_timeout_flag,
  input wire logic       unload_mismatch_alarm,
  input wire logic       unload_mismatch_flag,
  input wire logic       breaker_a_open_cmd,
  input wire logic [2:0] sync_alarm_class,
  input wire logic [2:0] unload_alarm_class
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Timeout message and flag
  a_msg_flag: assert property (sync_timeout_message |-> sync_timeout_flag)
    else $error("message without flag");
  a_msg_pulse: assert property (sync_timeout_message |=> !sync_timeout_message)
    else $error("message longer than a cycle");
  a_sync_idle: assert property (!sync_active [*8] |=> !sync_timeout_message)
    else $error("timeout with no sequence");
  // Unload alarm and open command
  a_flags_equal: assert property (unload_mismatch_alarm == unload_mismatch_flag)
    else $error("unload flag differs from alarm");
  a_alarm_opens: assert property ($rose(unload_mismatch_alarm) |-> ##[0:1] breaker_a_open_cmd)
    else $error("unload alarm without open command");
  a_open_holds: assert property (breaker_a_open_cmd && unload_active |=> breaker_a_open_cmd)
    else $error("open command dropped early");
  a_open_idle: assert property (!unload_active [*8] |=> !breaker_a_open_cmd)
    else $error("open command with no unload");
  a_alarm_latched: assert property (unload_mismatch_alarm && unload_active |=> unload_mismatch_alarm)
    else $error("alarm cleared while fault present");
  a_class_range: assert property (sync_alarm_class <= 3'h6 && unload_alarm_class <= 3'h6)
    else $error("alarm class out of range");

  // Main scenarios
  c_sync_to: cover property (sync_timeout_message);
  c_unld_alarm: cover property ($rose(unload_mismatch_alarm));
  c_trip_open: cover property ($rose(breaker_a_open_cmd) && !unload_mismatch_alarm);
endmodule

bind bsu_monitor bsu_chk i_bsu_chk (
  .clk(clk), .sys_rst(sys_rst), .sync_active(sync_active), .unload_active(unload_active),
  .sync_timeout_message(sync_timeout_message), .sync_timeout_flag(sync_timeout_flag),
  .unload_mismatch_alarm(unload_mismatch_alarm), .unload_mismatch_flag(unload_mismatch_flag),
  .breaker_a_open_cmd(breaker_a_open_cmd), .sync_alarm_class(sync_alarm_class),
  .unload_alarm_class(unload_alarm_class)
);

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic        clk, sys_rst, reg_wr, reg_rd, sync_active, unload_active, lock_monitoring, ext_ack;
  logic        run_unload, shed_load, sync_timeout_message, sync_timeout_flag, irq;
  logic        unload_mismatch_alarm, unload_mismatch_flag, breaker_a_open_cmd;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [9:0]  power_a;
  logic [2:0]  sync_alarm_class, unload_alarm_class;
  int          fail_count, n_compared, i, n_msg;

  bsu_monitor #(.SEC_CYCLES(10)) i_bsu_monitor (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_active(sync_active), .unload_active(unload_active),
    .lock_monitoring(lock_monitoring), .ext_ack(ext_ack), .power_a(power_a),
    .sync_timeout_message(sync_timeout_message), .sync_timeout_flag(sync_timeout_flag),
    .unload_mismatch_alarm(unload_mismatch_alarm), .unload_mismatch_flag(unload_mismatch_flag),
    .breaker_a_open_cmd(breaker_a_open_cmd), .sync_alarm_class(sync_alarm_class),
    .unload_alarm_class(unload_alarm_class), .irq(irq));

  bsu_breaker_model i_bsu_breaker_model (
    .clk(clk), .sys_rst(sys_rst), .run_unload(run_unload), .shed_load(shed_load),
    .open_cmd(breaker_a_open_cmd), .unload_active(unload_active), .power_a(power_a));

  // Clock
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  // Count timeout message pulses
  always @(posedge clk) begin
    if (sync_timeout_message === 1'b1)
      n_msg <= n_msg + 1;
  end

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    @(negedge clk);
    chk("rdata", reg_rdata, e);
  endtask

  task automatic test_done;
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Defaults after reset and an unmapped index
  task automatic t_reset;
    rd(4'h0, 16'h1101);
    rd(4'h1, 16'h003C);
    rd(4'h2, 16'h003C);
    rd(4'h3, 16'h001E);
    rd(4'hA, 16'h0000);
    chk("sclass", {13'h0, sync_alarm_class}, 16'h0001);
    chk("uclass", {13'h0, unload_alarm_class}, 16'h0001);
  endtask

  // Delay and trip limits, then short delays for the run
  task automatic t_clamp;
    wr(4'h1, 16'h0001); rd(4'h1, 16'h0003);
    wr(4'h1, 16'h03FF); rd(4'h1, 16'h03E7);
    wr(4'h2, 16'h0000); rd(4'h2, 16'h0001);
    wr(4'h3, 16'h0000); rd(4'h3, 16'h0005);
    wr(4'h3, 16'h001E);
    wr(4'h1, 16'h0003);
  endtask

  // Every alarm class on both alarms, one code beyond Control
  task automatic t_class;
    for (int k = 0; k < 8; k++) begin
      wr(4'h0, {1'b0, k[2:0], 1'b0, k[2:0], 8'h01});
      wt(2);
      chk("sclass", {13'h0, sync_alarm_class}, (k > 6) ? 16'h6 : k[15:0]);
      chk("uclass", {13'h0, unload_alarm_class}, (k > 6) ? 16'h6 : k[15:0]);
    end
  endtask

  // One sync sequence that outlasts the delay, then acknowledge
  task automatic sy(input logic [15:0] c, input logic l, input logic e, input logic a);
    int m;
    m = n_msg;
    wr(4'h0, c);
    lock_monitoring <= l;
    sync_active <= 1;
    wt(18);
    chk("early", {15'h0, sync_timeout_flag}, 16'h0);
    wt(27);
    chk("sflag", {15'h0, sync_timeout_flag}, {15'h0, e});
    chk("msg", 16'(n_msg - m), {15'h0, e});
    sync_active <= 0;
    wt(10);
    chk("after", {15'h0, sync_timeout_flag}, {15'h0, a});
    lock_monitoring <= 0;
    wr(4'h7, 16'h0003);
    wt(3);
    chk("acked", {15'h0, sync_timeout_flag}, 16'h0);
  endtask

  // Status bit raises irq only when unmasked, cleared by writing one
  task automatic t_irq;
    chk("masked", {15'h0, irq}, 16'h0);
    wr(4'h6, 16'h0001);
    wt(3);
    chk("irq", {15'h0, irq}, 16'h1);
    wr(4'h5, 16'h0007);
    wt(3);
    chk("cleared", {15'h0, irq}, 16'h0);
    wr(4'h6, 16'h0000);
  endtask

  // A restarted sequence times the full delay again
  task automatic t_restart;
    wr(4'h0, 16'h1101);
    sync_active <= 1;
    wt(18);
    sync_active <= 0;
    wt(8);
    sync_active <= 1;
    wt(18);
    chk("restart", {15'h0, sync_timeout_flag}, 16'h0);
    sync_active <= 0;
    wt(8);
  endtask

  // Unload sequence: trip by shed load, or by delay expiry, per control and lock setting
  task automatic t_unload(input logic shed, input logic [15:0] d, input logic [15:0] c, input logic l,
                          input logic e, input logic k);
    wr(4'h0, c);
    wr(4'h2, d);
    lock_monitoring <= l;
    shed_load <= shed;
    run_unload <= 1;
    for (i = 0; i < 200 && breaker_a_open_cmd !== 1'b1; i++) @(posedge clk);
    chk("open", {15'h0, breaker_a_open_cmd}, 16'h1);
    chk("alarm", {15'h0, unload_mismatch_alarm}, {15'h0, e});
    chk("uflag", {15'h0, unload_mismatch_flag}, {15'h0, e});
    rd(4'h4, {7'h00, l, shed, 1'b1, 3'h0, 1'b1, e, 1'b0});
    for (i = 0; i < 50 && breaker_a_open_cmd !== 1'b0; i++) @(posedge clk);
    chk("dropped", {15'h0, breaker_a_open_cmd}, 16'h0);
    run_unload <= 0;
    shed_load <= 0;
    wt(10);
    chk("latched", {15'h0, unload_mismatch_alarm}, {15'h0, k});
    ext_ack <= 1;
    wt(6);
    ext_ack <= 0;
    wt(6);
    chk("acked", {15'h0, unload_mismatch_alarm}, 16'h0);
    lock_monitoring <= 0;
  endtask

  // Main sequence
  initial begin
    {reg_wr, reg_rd, sync_active, lock_monitoring, ext_ack, run_unload, shed_load} = '0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    sys_rst = 1;
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    t_reset;
    t_clamp;
    t_class;
    sy(16'h1101, 0, 1, 1);
    t_irq;
    sy(16'h1103, 0, 1, 0);
    sy(16'h1100, 0, 0, 0);
    sy(16'h1105, 1, 0, 0);
    sy(16'h1101, 1, 1, 1);
    t_restart;
    t_unload(1, 16'h0009, 16'h1101, 0, 0, 0);
    t_unload(0, 16'h0002, 16'h1101, 1, 1, 1);
    t_unload(0, 16'h0002, 16'h1109, 0, 1, 0);
    t_unload(0, 16'h0002, 16'h1111, 1, 0, 0);
    test_done;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done;
  end
endmodule
